// *** hvtm_top.sv ***
// Functional notes
// - Primary vertical measurements come from the port named by the primary select.
// - A background engine measures the port named by the background select.
// - Vertical lock flag readable at byte 0x07 bit 7.
// - Raw vertical lock readable at byte 0x6A bit 1; it carries the same lock as the flag at 0x07 bit 7.
// - Primary measurements are trustworthy only while raw lock is one.
// - The measuring filter sits beside the video path and delays nothing.
// - Field 0 total half lines, 14 bits, at bytes 0x26 and 0x27.
// - Field 0 active lines, 13 bits, at bytes 0x09 and 0x0A.
// - Field 0 front porch, sync width, back porch at 0x2A, 0x2E, 0x32.
// - Field 1 total, front porch, width, back porch at 0x28 to 0x34.
// - Field 1 active lines, 13 bits, at bytes 0x0B and 0x0C.
// - Field 1 values are valid only while the interlace bit is one.
// - Interlace status at byte 0x0B bit 5, one means interlaced.
// - Interlace status is valid only while filter lock and raw lock hold.
// - Vertical sync polarity at byte 0x05 bit 4, one means active high.
// - Background values are valid only while the background lock flag is high.
// - Lock is declared when sync lands on the same count two frames running.
// - Lock is dropped as soon as sync lands on a count different from the previous frame.
// - Background readbacks refresh only on a software update request.
`timescale 1ns/100ps

module hvtm_meas #(
  parameter int NP = 8
) (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic [hvtm_pkg::SEL_W-1:0]           sel,
  input  wire logic [NP-1:0]                        pclk_s,
  input  wire logic [NP-1:0]                        vs_s,
  input  wire logic [NP-1:0]                        hs_s,
  input  wire logic [NP-1:0]                        de_s,
  output logic                                      pol_r,
  output logic                                      lock_r,
  output logic                                      intl_r,
  output logic [1:0][hvtm_pkg::HL_W-1:0]            tot_r,
  output logic [1:0][hvtm_pkg::HL_W-1:0]            fp_r,
  output logic [1:0][hvtm_pkg::HL_W-1:0]            pw_r,
  output logic [1:0][hvtm_pkg::HL_W-1:0]            bp_r,
  output logic [1:0][hvtm_pkg::ACT_W-1:0]           act_r
);
  logic                        pclk_d_r;
  logic                        hs_d_r;
  logic                        vsa_d_r;
  logic                        de_d_r;
  logic                        fld_r;
  logic                        seen_de_r;
  logic [hvtm_pkg::PIX_W-1:0]  pix_cnt_r;
  logic [hvtm_pkg::PIX_W-1:0]  line_len_r;
  logic [hvtm_pkg::HL_W-1:0]   hl_cnt_r;
  logic [hvtm_pkg::HL_W-1:0]   pw_mark_r;
  logic [hvtm_pkg::HL_W-1:0]   de_first_r;
  logic [hvtm_pkg::HL_W-1:0]   de_last_r;
  logic [hvtm_pkg::ACT_W-1:0]  act_cnt_r;

  // Selected port and the edges seen on it by the system clock.
  wire pclk_m   = pclk_s[sel];
  wire vs_m     = vs_s[sel];
  wire hs_m     = hs_s[sel];
  wire de_m     = de_s[sel];
  wire vs_act   = ~(vs_m ^ pol_r);
  wire pix_tick = pclk_m & ~pclk_d_r;
  wire hs_lead  = hs_m & ~hs_d_r;
  wire vs_lead  = vs_act & ~vsa_d_r;
  wire vs_trail = ~vs_act & vsa_d_r;
  wire de_rise  = de_m & ~de_d_r;
  wire de_fall  = ~de_m & de_d_r;
  wire mid_tick = pix_tick & (line_len_r != '0) & (pix_cnt_r == (line_len_r >> 1));
  wire half_tick = hs_lead | mid_tick;
  // Position including a tick in this very cycle, so a field end on a line start loses no half line.
  wire [hvtm_pkg::HL_W-1:0] hl_pos = hl_cnt_r + {{(hvtm_pkg::HL_W-1){1'b0}}, half_tick};
  // A field whose sync lead falls in the second half of a line is field 1.
  wire late_half = ~hs_lead & (line_len_r != '0) & (pix_cnt_r >= (line_len_r >> 1));
  // An empty count after reset is never taken as a repeat, so no false lock follows reset.
  wire match    = (hl_pos == tot_r[fld_r]) & (hl_pos != '0);

  // Edge history of the selected port.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_d_r <= 1'b0;
      hs_d_r   <= 1'b0;
      vsa_d_r  <= 1'b0;
      de_d_r   <= 1'b0;
    end else begin
      pclk_d_r <= pclk_m;
      hs_d_r   <= hs_m;
      vsa_d_r  <= vs_act;
      de_d_r   <= de_m;
    end
  end

  // Sync is never asserted during active video, so its level there is the idle level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_r <= 1'b0;
    end else if (de_m) begin
      pol_r <= ~vs_m;
    end
  end

  // Pixel counter per line; its midpoint gives the second half-line tick.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_cnt_r   <= '0;
      line_len_r  <= '0;
    end else if (hs_lead) begin
      pix_cnt_r   <= '0;
      line_len_r  <= pix_cnt_r;
    end else begin
      pix_cnt_r   <= pix_tick ? pix_cnt_r + 16'h0001 : pix_cnt_r;
    end
  end

  // Running half-line position in the field and the marks of its phases.
  always_ff @(posedge aclk) begin
    if (!aresetn || vs_lead) begin
      hl_cnt_r   <= '0;
      act_cnt_r  <= '0;
      seen_de_r  <= 1'b0;
      pw_mark_r  <= '0;
      de_first_r <= '0;
      de_last_r  <= '0;
    end else begin
      hl_cnt_r   <= half_tick ? hl_cnt_r + 14'h0001 : hl_cnt_r;
      act_cnt_r  <= de_rise ? act_cnt_r + 13'h0001 : act_cnt_r;
      seen_de_r  <= seen_de_r | de_rise;
      pw_mark_r  <= vs_trail ? hl_pos : pw_mark_r;
      de_first_r <= (de_rise && !seen_de_r) ? hl_pos : de_first_r;
      de_last_r  <= de_fall ? hl_pos : de_last_r;
    end
  end

  // Field end: store results in the slot of the finished field and judge lock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tot_r  <= '0;
      fp_r   <= '0;
      pw_r   <= '0;
      bp_r   <= '0;
      act_r  <= '0;
      lock_r <= 1'b0;
      fld_r  <= 1'b0;
      intl_r <= 1'b0;
    end else if (vs_lead) begin
      tot_r[fld_r] <= hl_pos;
      pw_r[fld_r]  <= pw_mark_r;
      bp_r[fld_r]  <= de_first_r - pw_mark_r;
      fp_r[fld_r]  <= hl_pos - de_last_r;
      act_r[fld_r] <= act_cnt_r;
      lock_r       <= match;
      fld_r        <= late_half;
      intl_r       <= fld_r ^ late_half;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_field_end;
    vs_lead ##1 1'b1;
  endsequence

  AST_POL_TRACKS: assert property (de_m |=> pol_r == !$past(vs_m))
    else $error("sync polarity did not follow idle level");
  AST_LOCK_ON_MATCH: assert property ((match && vs_lead) |=> lock_r)
    else $error("lock not declared on repeated count");
  AST_UNLOCK_ON_MISS: assert property ((!match && vs_lead) |=> !lock_r)
    else $error("lock kept on differing count");
  AST_LOCK_HOLDS: assert property (!vs_lead |=> $stable(lock_r))
    else $error("lock changed between field ends");
  AST_TOTAL_STORE: assert property (s_field_end |-> tot_r[$past(fld_r)] == $past(hl_pos))
    else $error("total half lines not stored");
  AST_ACTIVE_STORE: assert property (s_field_end |-> act_r[$past(fld_r)] == $past(act_cnt_r))
    else $error("active lines not stored");
  AST_PORCH_STORE: assert property (s_field_end |-> fp_r[$past(fld_r)] == $past(hl_pos - de_last_r))
    else $error("front porch not stored");
  AST_INTL_ALTERNATE: assert property ((vs_lead && (fld_r != late_half)) |=> intl_r)
    else $error("alternating fields not reported as interlaced");
  AST_INTL_PROGRESSIVE: assert property ((vs_lead && (fld_r == late_half)) |=> !intl_r)
    else $error("repeated field parity reported as interlaced");
endmodule

module hvtm_top #(
  parameter int NP     = 8,
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [NP-1:0]     port_pclk,
  input  wire logic [NP-1:0]     port_vsync,
  input  wire logic [NP-1:0]     port_hsync,
  input  wire logic [NP-1:0]     port_de,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  logic [NP-1:0][3:0]               sync1_r;
  logic [NP-1:0][3:0]               sync2_r;
  logic [NP-1:0]                    pclk_s, vs_s, hs_s, de_s;
  logic [7:0]                       ctrl_r;
  logic                             aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [hvtm_pkg::IDX_W-1:0]       aw_idx_r;
  logic [7:0]                       w_byte_r;
  logic                             w_lane0_r;
  logic [1:0]                       bresp_r, rresp_r;
  logic [31:0]                      rdata_r;
  logic [7:0]                       rd_byte;
  logic                             rd_hit;
  logic                             p_pol, p_lock, p_intl, b_pol, b_lock, b_intl;
  logic [1:0][hvtm_pkg::HL_W-1:0]   p_tot, p_fp, p_pw, p_bp, b_tot, b_fp, b_pw, b_bp;
  logic [1:0][hvtm_pkg::ACT_W-1:0]  p_act, b_act;
  logic [hvtm_pkg::ACT_W-1:0]       bg_tot_r, bg_act_r;
  logic                             bg_lock_r, bg_intl_r;

  // Two-flop synchronisers for every pin of every port.
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_r[gi] <= 4'h0;
          sync2_r[gi] <= 4'h0;
        end else begin
          sync1_r[gi] <= {port_de[gi], port_hsync[gi], port_vsync[gi], port_pclk[gi]};
          sync2_r[gi] <= sync1_r[gi];
        end
      end
      assign {de_s[gi], hs_s[gi], vs_s[gi], pclk_s[gi]} = sync2_r[gi];
    end
  endgenerate

  // Both engines only observe the synchronised pins; nothing here feeds the video path.
  hvtm_meas #(.NP(NP)) u_prim (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (ctrl_r[hvtm_pkg::CTRL_PSEL +: hvtm_pkg::SEL_W]),
    .pclk_s  (pclk_s),
    .vs_s    (vs_s),
    .hs_s    (hs_s),
    .de_s    (de_s),
    .pol_r   (p_pol),
    .lock_r  (p_lock),
    .intl_r  (p_intl),
    .tot_r   (p_tot),
    .fp_r    (p_fp),
    .pw_r    (p_pw),
    .bp_r    (p_bp),
    .act_r   (p_act)
  );

  hvtm_meas #(.NP(NP)) u_bg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (ctrl_r[hvtm_pkg::CTRL_BSEL +: hvtm_pkg::SEL_W]),
    .pclk_s  (pclk_s),
    .vs_s    (vs_s),
    .hs_s    (hs_s),
    .de_s    (de_s),
    .pol_r   (b_pol),
    .lock_r  (b_lock),
    .intl_r  (b_intl),
    .tot_r   (b_tot),
    .fp_r    (b_fp),
    .pw_r    (b_pw),
    .bp_r    (b_bp),
    .act_r   (b_act)
  );

  // Write decode; the update request is a self-clearing bit of the control byte.
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire wr_do     = aw_hold_r & w_hold_r;
  wire wr_ctrl   = wr_do & w_lane0_r & (aw_idx_r == hvtm_pkg::IDX_CTRL);
  wire bg_req    = wr_ctrl & w_byte_r[hvtm_pkg::CTRL_REQ];
  wire ar_take   = s_axi_arvalid & s_axi_arready;
  wire [hvtm_pkg::IDX_W-1:0] rd_idx = s_axi_araddr[2 +: hvtm_pkg::IDX_W];

  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Write channel: address and data are held until both are present.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_idx_r  <= '0;
      w_byte_r  <= 8'h00;
      w_lane0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= hvtm_pkg::RESP_OKAY;
      ctrl_r    <= hvtm_pkg::CTRL_RST;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[2 +: hvtm_pkg::IDX_W];
      end
      if (w_take) begin
        w_hold_r  <= 1'b1;
        w_byte_r  <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (aw_idx_r == hvtm_pkg::IDX_CTRL) ? hvtm_pkg::RESP_OKAY : hvtm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r  <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_r <= w_byte_r & ~(8'h01 << hvtm_pkg::CTRL_REQ);
      end
    end
  end

  // Background snapshot is refreshed only by the update request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bg_tot_r  <= '0;
      bg_act_r  <= '0;
      bg_lock_r <= 1'b0;
      bg_intl_r <= 1'b0;
    end else if (bg_req) begin
      bg_tot_r  <= b_tot[0][hvtm_pkg::HL_W-1:1];
      bg_act_r  <= b_act[0];
      bg_lock_r <= b_lock;
      bg_intl_r <= b_intl;
    end
  end

  // Read selection by register index; unmapped indices answer with an error.
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      hvtm_pkg::IDX_POL:                          rd_byte = 8'({7'h00, p_pol} << hvtm_pkg::BIT_POL);
      hvtm_pkg::IDX_VLOCK:                        rd_byte = 8'({7'h00, p_lock} << hvtm_pkg::BIT_VLOCK);
      hvtm_pkg::IDX_RAWLOCK:                      rd_byte = 8'({7'h00, p_lock} << hvtm_pkg::BIT_RAW);
      hvtm_pkg::IDX_F0ACT:                        rd_byte = {3'h0, p_act[0][12:8]};
      hvtm_pkg::IDX_F0ACT + hvtm_pkg::IDX_NEXT:   rd_byte = p_act[0][7:0];
      hvtm_pkg::IDX_F1ACT:                        rd_byte = 8'({7'h00, p_intl} << hvtm_pkg::BIT_INTL) | {3'h0, p_act[1][12:8]};
      hvtm_pkg::IDX_F1ACT + hvtm_pkg::IDX_NEXT:   rd_byte = p_act[1][7:0];
      hvtm_pkg::IDX_F0TOT:                        rd_byte = {2'h0, p_tot[0][13:8]};
      hvtm_pkg::IDX_F0TOT + hvtm_pkg::IDX_NEXT:   rd_byte = p_tot[0][7:0];
      hvtm_pkg::IDX_F1TOT:                        rd_byte = {2'h0, p_tot[1][13:8]};
      hvtm_pkg::IDX_F1TOT + hvtm_pkg::IDX_NEXT:   rd_byte = p_tot[1][7:0];
      hvtm_pkg::IDX_F0FP:                         rd_byte = {2'h0, p_fp[0][13:8]};
      hvtm_pkg::IDX_F0FP + hvtm_pkg::IDX_NEXT:    rd_byte = p_fp[0][7:0];
      hvtm_pkg::IDX_F1FP:                         rd_byte = {2'h0, p_fp[1][13:8]};
      hvtm_pkg::IDX_F1FP + hvtm_pkg::IDX_NEXT:    rd_byte = p_fp[1][7:0];
      hvtm_pkg::IDX_F0PW:                         rd_byte = {2'h0, p_pw[0][13:8]};
      hvtm_pkg::IDX_F0PW + hvtm_pkg::IDX_NEXT:    rd_byte = p_pw[0][7:0];
      hvtm_pkg::IDX_F1PW:                         rd_byte = {2'h0, p_pw[1][13:8]};
      hvtm_pkg::IDX_F1PW + hvtm_pkg::IDX_NEXT:    rd_byte = p_pw[1][7:0];
      hvtm_pkg::IDX_F0BP:                         rd_byte = {2'h0, p_bp[0][13:8]};
      hvtm_pkg::IDX_F0BP + hvtm_pkg::IDX_NEXT:    rd_byte = p_bp[0][7:0];
      hvtm_pkg::IDX_F1BP:                         rd_byte = {2'h0, p_bp[1][13:8]};
      hvtm_pkg::IDX_F1BP + hvtm_pkg::IDX_NEXT:    rd_byte = p_bp[1][7:0];
      hvtm_pkg::IDX_BGACT:                        rd_byte = {3'h0, bg_act_r[12:8]};
      hvtm_pkg::IDX_BGACT + hvtm_pkg::IDX_NEXT:   rd_byte = bg_act_r[7:0];
      hvtm_pkg::IDX_BGTOT:                        rd_byte = {3'h0, bg_tot_r[12:8]};
      hvtm_pkg::IDX_BGTOT + hvtm_pkg::IDX_NEXT:   rd_byte = bg_tot_r[7:0];
      hvtm_pkg::IDX_BGSTAT:                       rd_byte = 8'({7'h00, bg_lock_r} << hvtm_pkg::BIT_BGLOCK)
                                                          | 8'({7'h00, bg_intl_r} << hvtm_pkg::BIT_BGINTL);
      hvtm_pkg::IDX_CTRL:                         rd_byte = ctrl_r;
      default:                                    rd_hit  = 1'b0;
    endcase
  end

  // Read channel: one cycle from address taken to data valid.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= hvtm_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= rd_hit ? hvtm_pkg::RESP_OKAY : hvtm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_BG_HOLD: assert property (!bg_req |=> $stable(bg_tot_r) && $stable(bg_lock_r))
    else $error("background readback changed without request");
  AST_BG_CAPTURE: assert property (bg_req |=> bg_lock_r == $past(b_lock))
    else $error("background lock not captured on request");
  AST_REQ_SELF_CLEAR: assert property (wr_ctrl |=> !ctrl_r[hvtm_pkg::CTRL_REQ])
    else $error("update request bit did not clear");
endmodule

// *** hvtm_pkg.sv ***
package hvtm_pkg;
  // Widths of the measurement fields and of the port selects.
  localparam int HL_W  = 14;
  localparam int ACT_W = 13;
  localparam int SEL_W = 3;
  localparam int IDX_W = 8;
  localparam int PIX_W = 16;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_POL     = 8'h05;
  localparam logic [7:0] IDX_VLOCK   = 8'h07;
  localparam logic [7:0] IDX_F0ACT   = 8'h09;
  localparam logic [7:0] IDX_F1ACT   = 8'h0b;
  localparam logic [7:0] IDX_F0TOT   = 8'h26;
  localparam logic [7:0] IDX_F1TOT   = 8'h28;
  localparam logic [7:0] IDX_F0FP    = 8'h2a;
  localparam logic [7:0] IDX_F1FP    = 8'h2c;
  localparam logic [7:0] IDX_F0PW    = 8'h2e;
  localparam logic [7:0] IDX_F1PW    = 8'h30;
  localparam logic [7:0] IDX_F0BP    = 8'h32;
  localparam logic [7:0] IDX_F1BP    = 8'h34;
  localparam logic [7:0] IDX_RAWLOCK = 8'h6a;
  localparam logic [7:0] IDX_BGACT   = 8'he6;
  localparam logic [7:0] IDX_BGTOT   = 8'he8;
  localparam logic [7:0] IDX_BGSTAT  = 8'hea;
  localparam logic [7:0] IDX_CTRL    = 8'hf0;
  localparam logic [7:0] IDX_NEXT    = 8'h01;

  // Bit positions inside the status and control bytes.
  localparam int BIT_POL     = 4;
  localparam int BIT_VLOCK   = 7;
  localparam int BIT_INTL    = 5;
  localparam int BIT_RAW     = 1;
  localparam int BIT_BGLOCK  = 1;
  localparam int BIT_BGINTL  = 0;
  localparam int CTRL_PSEL   = 0;
  localparam int CTRL_BSEL   = 4;
  localparam int CTRL_REQ    = 7;

  // Reset values and bus responses.
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hvtm_src.sv ***
`timescale 1ns/100ps
// Upstream video source on one port; rasters are 16 pixels a line, the clock stops while idle.
module hvtm_src (
  input  wire logic       en,
  input  wire logic       pol,
  input  wire logic       intl,
  input  wire logic [7:0] lines,
  output logic            pclk,
  output logic            vs,
  output logic            hs,
  output logic            de
);
  logic       odd;
  logic       p;
  logic       a;
  logic [7:0] n;

  // Sync one line, back porch two, four data lines, the rest front porch; odd fields start mid-line.
  initial begin
    pclk = 1'b0;
    odd = 1'b0;
    forever begin
      if (!en) begin
        vs = ~pol;
        hs = 1'b0;
        de = 1'b0;
        #80;
      end else begin
        n = lines;
        p = pol;
        odd = intl & ~odd;
        for (int l = 0; l < n; l++) begin
          for (int x = 0; x < 16; x++) begin
            a = (l == 0 && !(odd && x < 8)) || (odd && l == 1 && x < 8);
            vs = a ~^ p;
            hs = (x < 2);
            de = (l >= 3 && l < 7 && x >= 2);
            pclk = 1'b0;
            #80;
            pclk = 1'b1;
            #80;
          end
        end
      end
    end
  end
endmodule

// *** hdmi_vertical_timing_measure_bench.sv ***
`timescale 1ns/100ps
module hdmi_vertical_timing_measure_bench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        en, pol, intl, pclk, vs, hs, de;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  lines;
  int          err_count, check_count;

  // The source drives port 2; the other ports stay quiet.
  hvtm_src i_src (.en(en), .pol(pol), .intl(intl), .lines(lines), .pclk(pclk), .vs(vs), .hs(hs), .de(de));
  hvtm_top i_dut (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .port_pclk     ({5'h00, pclk, 2'h0}),
    .port_vsync    ({5'h00, vs, 2'h0}),
    .port_hsync    ({5'h00, hs, 2'h0}),
    .port_de       ({5'h00, de, 2'h0}),
    .s_axi_awaddr  (awaddr),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (4'hf),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_bresp   (bresp),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (bready),
    .s_axi_araddr  (araddr),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (rready)
  );

  // The clock toggles every half period.
  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: %s saw %h wanted %h", $time, m, s, e);
    end
  endtask

  // Readies are looked at on the falling edge, so they are what the next rising edge samples.
  task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
    logic a, w, b;
    int   n;
    @(posedge aclk);
    awaddr  <= {2'h0, i, 2'h0};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      a = awready;
      w = wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end while (!b && n < 200);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    logic a, v;
    int   n;
    @(posedge aclk);
    araddr  <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      a = arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      n++;
    end while (!v && n < 200);
    rready <= 1'b0;
  endtask

  task automatic rv(input logic [7:0] i, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(i, d, r);
    chk({30'h0, r}, 32'h0, m);
    chk(d, e, m);
  endtask

  // A field is read high byte first, then the low byte at the next index.
  task automatic rf(input logic [7:0] i, input int w, output logic [31:0] v);
    logic [31:0] h, l;
    logic [1:0]  r;
    rd(i, h, r);
    rd(i + 8'h01, l, r);
    v = ((h & ((32'h1 << (w - 8)) - 32'h1)) << 8) | l;
  endtask

  task automatic cf(input logic [7:0] i, input int w, input logic [31:0] e, input string m);
    logic [31:0] v;
    rf(i, w, v);
    chk(v, e, m);
  endtask

  task automatic wl(input logic e);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      rd(8'h07, d, r);
      n++;
    end while (d[7] !== e && n < 8000);
  endtask

  task automatic t_reg;
    logic [31:0] d;
    logic [1:0]  r;
    rv(8'h07, 32'h0, "lock at reset");
    rv(8'h6a, 32'h0, "raw lock at reset");
    rv(8'hf0, 32'h0, "control at reset");
    rd(8'h00, d, r);
    chk({30'h0, r}, 32'h2, "unmapped read");
    wr(8'h26, 8'h55, r);
    chk({30'h0, r}, 32'h2, "write to read-only");
    rv(8'h26, 32'h0, "read-only unchanged");
    $display("test registers done");
  endtask

  task automatic t_sel;
    logic [1:0] r;
    wr(8'hf0, 8'h20, r);
    en    <= 1'b1;
    pol   <= 1'b1;
    lines <= 8'd8;
    repeat (3 * 8 * 512) @(posedge aclk);
    rv(8'h07, 32'h0, "lock on idle primary port");
    rv(8'hea, 32'h0, "background before request");
    wr(8'hf0, 8'ha0, r);
    rv(8'hf0, 32'h20, "request clears itself");
    rv(8'hea, 32'h2, "background lock");
    cf(8'he8, 13, 32'd8, "background total");
    cf(8'he6, 13, 32'd4, "background active");
    $display("test port selects done");
  endtask

  task automatic t_prog;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'hf0, 8'h22, r);
    wl(1'b1);
    rv(8'h07, 32'h80, "lock");
    rv(8'h6a, 32'h2, "raw lock");
    rv(8'h05, 32'h10, "polarity high");
    rd(8'h0b, d, r);
    chk(d[5], 1'b0, "progressive");
    cf(8'h26, 14, 32'd16, "f0 total");
    cf(8'h09, 13, 32'd4, "f0 active");
    cf(8'h2a, 14, 32'd2, "f0 front porch");
    cf(8'h2e, 14, 32'd2, "f0 sync width");
    cf(8'h32, 14, 32'd4, "f0 back porch");
    $display("test progressive done");
  endtask

  task automatic t_relock;
    lines <= 8'd9;
    wl(1'b0);
    rv(8'h6a, 32'h0, "raw lock dropped");
    wl(1'b1);
    cf(8'h26, 14, 32'd18, "f0 total changed");
    cf(8'h2a, 14, 32'd4, "f0 front porch changed");
    $display("test relock done");
  endtask

  task automatic t_intl;
    logic [31:0] d, a, b;
    logic [1:0]  r;
    pol   <= 1'b0;
    intl  <= 1'b1;
    lines <= 8'd8;
    wl(1'b0);
    wl(1'b1);
    repeat (2 * 8 * 512) @(posedge aclk);
    rv(8'h05, 32'h0, "polarity low");
    rv(8'h6a, 32'h2, "raw lock interlaced");
    rd(8'h0b, d, r);
    chk(d[5], 1'b1, "interlaced");
    rf(8'h26, 14, a);
    rf(8'h28, 14, b);
    chk(a + b, 32'd32, "field totals");
    cf(8'h0b, 13, 32'd4, "f1 active");
    cf(8'h30, 14, 32'd2, "f1 sync width");
    $display("test interlaced done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Reset for 20 cycles, then run every scenario.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, en, pol, intl} = 9'h000;
    {awaddr, araddr, wdata, lines} = 64'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reg;
    t_sel;
    t_prog;
    t_relock;
    t_intl;
    results;
  end

  // Watchdog for a hung run.
  initial begin
    repeat (90000) @(posedge aclk);
    err_count++;
    results;
  end
endmodule
